// file: dv/rcr_host_model.sv
// Behavioural microprocessor on the control bus of the register bank.
// Assumes the bench resolves the shared data bus from the register bank enable alone.
`timescale 1ns/1ns
module rcr_host_model (
	// Clock
	input  wire logic       clk_in,
	// Control bus
	output logic            cs_n_out,
	output logic            rw_out,
	output logic      [3:0] addr_out,
	output logic      [7:0] data_out,
	input  wire logic [7:0] data_in
);
	initial begin
		cs_n_out = 1'b1;
		rw_out = 1'b1;
		addr_out = 4'h0;
		data_out = 8'h00;
	end
	// Strobe low 8 clocks, fields steady 6 clocks before it and 8 after
	task automatic access(input logic rw, input logic [3:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk_in);
		#10;
		rw_out = rw;
		addr_out = a;
		// Released bus shows a changed pattern, never the last value
		data_out = rw ? ~data_out : d;
		repeat (6) @(posedge clk_in);
		#10;
		cs_n_out = 1'b0;
		repeat (8) @(posedge clk_in);
		q = data_in;
		#10;
		cs_n_out = 1'b1;
		repeat (8) @(posedge clk_in);
	endtask : access
endmodule : rcr_host_model

// file: dv/tb_top.sv
// Self-checking bench for the receiver control register bank.
// Assumes a 10 MHz clock and the host model for bus cycles.
`timescale 1ns/1ns
module tb_top;
	import rcr_pkg::*;
	logic        clk_in;
	logic        rst_in;
	logic [11:0] x_in;
	logic        cs_n, rw, oe_n, i_o, q_o, bs, fs, so_n;
	logic        ss_n, as_n;
	logic [1:0]  held;
	logic [3:0]  addr;
	logic [7:0]  host_d, dut_d, q;
	wire  [7:0]  bus_d = oe_n ? host_d : dut_d;
	int          err_total, samples_checked, n, n2, n3;
	// Address, write value, expected read
	logic [19:0] rows [9] = '{{4'h0, 8'ha5, 8'ha5}, {4'h3, 8'hff, 8'h0f},
		{4'h7, 8'hff, 8'h0f}, {4'h9, 8'hff, 8'h3f}, {4'h8, 8'h5a, 8'h5a},
		{4'h6, 8'h20, 8'h20}, {4'h2, 8'h3c, 8'h3c}, {4'h1, 8'hc3, 8'hc3},
		{4'hb, 8'hff, 8'h00}};
	rcr_core #(.FIFO_DEPTH(16)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .x_in(x_in),
		.ss_n_in(ss_n), .accum_sync_n_in(as_n), .cs_n_in(cs_n), .rw_in(rw),
		.addr_in(addr), .data_in(bus_d), .data_out(dut_d), .data_oe_n_out(oe_n),
		.i_out(i_o), .q_out(q_o), .bit_strobe_out(bs), .frame_strobe_out(fs),
		.sync_n_out(so_n));
	rcr_host_model i_host (.clk_in(clk_in), .cs_n_out(cs_n), .rw_out(rw),
		.addr_out(addr), .data_out(host_d), .data_in(bus_d));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// One-clock low pulse on the system sync pin
	task automatic pulse_ss;
		@(posedge clk_in);
		#10;
		ss_n = 1'b0;
		@(posedge clk_in);
		#10;
		ss_n = 1'b1;
	endtask : pulse_ss
	// Free-running input ramp keeps the datapath busy
	always @(posedge clk_in) x_in <= #10 x_in + 12'h001;
	initial begin
		err_total = 0;
		samples_checked = 0;
		x_in = 12'h000;
		ss_n = 1'b1;
		as_n = 1'b1;
		rst_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#10;
		rst_in = 1'b0;
		foreach (rows[k]) begin
			i_host.access(1'b0, rows[k][19:16], rows[k][15:8], q);
			i_host.access(1'b1, rows[k][19:16], 8'h00, q);
			chk("readback", rows[k][7:0], q);
		end
		$display("register table test done");
		repeat (4) @(posedge clk_in);
		chk("bus enable idle", 8'h01, {7'h00, oe_n});
		// Back to 64-clock frames; the sync pulse restarts a frame count left past its end
		i_host.access(1'b0, REG_RATIO_HI, 8'h00, q);
		i_host.access(1'b0, REG_RATIO_LO, 8'h0f, q);
		// Inverted pulse frame strobe, half-rate bits, interleaved pins
		i_host.access(1'b0, REG_SERFMT, 8'h81, q);
		i_host.access(1'b0, REG_FILTFMT, 8'h30, q);
		pulse_ss();
		repeat (4) @(posedge clk_in);
		n = 0;
		n2 = 0;
		n3 = 0;
		repeat (128) begin
			@(posedge clk_in);
			#20;
			if (fs === 1'b0) n++;
			if (bs === 1'b1) n2++;
			if (i_o !== q_o) n3++;
		end
		chk("frame strobe lows", 8'h02, n[7:0]);
		chk("bit strobe pulses", 8'h40, n2[7:0]);
		chk("interleave mismatch", 8'h00, n3[7:0]);
		$display("frame strobe test done");
		// Gated clock: strobes freeze while the accumulator sync pin stays high
		i_host.access(1'b0, REG_FILTFMT, 8'h80, q);
		held = {fs, bs};
		n = 0;
		repeat (128) begin
			@(posedge clk_in);
			#20;
			if ({fs, bs} !== held) n++;
		end
		chk("gated strobe changes", 8'h00, n[7:0]);
		i_host.access(1'b0, REG_FILTFMT, 8'h00, q);
		$display("clock gating test done");
		// System sync switched off: a pin pulse must not reach the sync output
		i_host.access(1'b0, REG_SYNC, 8'h01, q);
		pulse_ss();
		n = 0;
		repeat (6) begin
			@(posedge clk_in);
			#20;
			if (so_n === 1'b0) n++;
		end
		chk("disabled sync lows", 8'h00, n[7:0]);
		// Counter sync with short period: one low clock per 256
		i_host.access(1'b0, REG_SYNC, 8'hc1, q);
		n = 0;
		repeat (512) begin
			@(posedge clk_in);
			#20;
			if (so_n === 1'b0) n++;
		end
		chk("sync out lows", 8'h02, n[7:0]);
		$display("sync counter test done");
		// Reset in mid-run, then reset values read back
		@(posedge clk_in);
		#10;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#10;
		rst_in = 1'b0;
		i_host.access(1'b1, REG_RATIO_LO, 8'h00, q);
		chk("ratio_lo reset", RATIO_LO_RST, q);
		i_host.access(1'b1, REG_TW_B0, 8'h00, q);
		chk("tw_b0 reset", CFG_RST, q);
		$display("reset test done");
		give_verdict();
	end
endmodule : tb_top

// file: inc/rcr_pkg.sv
// Constants for the receiver control register bank.
// Assumes an 8-bit control bus with a 4-bit address and one sample clock.
package rcr_pkg;
	// Register addresses
	localparam logic [3:0] REG_TW_B0    = 4'h0;
	localparam logic [3:0] REG_TW_B1    = 4'h1;
	localparam logic [3:0] REG_TW_B2    = 4'h2;
	localparam logic [3:0] REG_TW_B3    = 4'h3;
	localparam logic [3:0] REG_SYNC     = 4'h4;
	localparam logic [3:0] REG_SERFMT   = 4'h5;
	localparam logic [3:0] REG_FILTFMT  = 4'h6;
	localparam logic [3:0] REG_SCALE    = 4'h7;
	localparam logic [3:0] REG_RATIO_LO = 4'h8;
	localparam logic [3:0] REG_RATIO_HI = 4'h9;
	localparam logic [3:0] REG_STATUS   = 4'ha;
	localparam logic [3:0] REG_SIGSUM   = 4'hb;
	localparam logic [3:0] REG_I_LO     = 4'hc;
	localparam logic [3:0] REG_I_HI     = 4'hd;
	localparam logic [3:0] REG_Q_LO     = 4'he;
	localparam logic [3:0] REG_Q_HI     = 4'hf;
	localparam int NUM_CFG = 10;
	// sync_control fields
	localparam int SC_SS_OFF    = 0;
	localparam int SC_RELOAD    = 1;
	localparam int SC_SUBST     = 2;
	localparam int SC_LOAD      = 3;
	localparam int SC_SYNC_LOAD = 4;
	localparam int SC_RAMP_INPUT_SEL      = 5;
	localparam int SC_TEST      = 6;
	localparam int SC_CNT_SEL   = 7;
	// serial_out_format fields
	localparam int OF_RATE_LSB  = 0;
	localparam int OF_BS_SHAPE  = 4;
	localparam int OF_BS_INV    = 5;
	localparam int OF_FS_SHAPE  = 6;
	localparam int OF_FS_INV    = 7;
	// filter_format_control fields
	localparam int FF_WIDE      = 0;
	localparam int FF_REAL      = 1;
	localparam int FF_OFFSET    = 2;
	localparam int FF_FLIP      = 3;
	localparam int FF_ILV       = 4;
	localparam int FF_MSB       = 5;
	localparam int FF_RAMP      = 6;
	localparam int FF_GATE      = 7;
	// capture_status fields
	localparam int ST_READY     = 0;
	localparam int ST_OVF       = 2;
	localparam int ST_REALFS    = 7;
	// Read masks for partly used registers
	localparam logic [7:0] MASK_NIBBLE = 8'h0f;
	localparam logic [7:0] MASK_RATIO  = 8'h3f;
	localparam logic [7:0] MASK_STATUS = 8'hfd;
	// Reset values
	localparam logic [7:0]  CFG_RST      = 8'h00;
	localparam logic [7:0]  RATIO_LO_RST = 8'h0f;
	localparam logic [11:0] RAMP_START   = 12'h800;
	// Sync counter periods as powers of two
	localparam int SYNC_LONG_LOG2  = 20;
	localparam int SYNC_SHORT_LOG2 = 8;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} rcr_bus_t;
endpackage : rcr_pkg

// file: logic/rcr_core.sv
// Receiver control register bank with the sync, tuning and serial output logic it steers.
// Assumes x, ss and as pins are synchronous to clk_in; the control bus is not.
// Operation
// - Tuning word is four bytes, low first; top byte uses only four bits.
// - Sync-mode bit 0 makes the system sync input ignored.
// - Accumulator free runs unless reload enabled; low sync reloads from frequency.
// - Substitute bit uses system sync instead of accumulator sync pin, unless sync-mode bit 0 is set.
// - Load bit copies tuning word, repeating on every tuning word write.
// - Synchronous load copies tuning word when selected accumulator sync is low.
// - Diagnostic sync reinitialises counters and accumulators every sync period.
// - Counter select takes internal sync from counter, shown on sync output.
// - Speed field makes each bit last two to the field power clocks.
// - Bit strobe pulses before transitions, or 50% clock; invertible.
// - Frame strobe pulses before frame, or spans first bit; invertible.
// - Bit and frame strobe polarities invert independently.
// - Filter bit 0 selects the wider passband filter.
// - Real format doubles output rate; host also sets offset and frame bit.
// - Offset bit centres the complex spectrum at half the sample rate.
// - Flip bit inverts the output spectrum.
// - Interleave sends alternating 16-bit I and Q on both pins.
// - Samples go LSB first, or MSB first with filter bit 5.
// - Ramp bit replaces input with ramp from -2048 to +2047, wrapping.
// - Gating bit lets accumulator sync pin gate the internal clock.
// - Gain field shifts output by its value; upper bits unused.
// - Gain overflow saturates the sample and sets the overflow flag.
// - Decimation field holds ratio minus one, host keeps 15 to 16383.
// - Write on strobe fall with write selected; read with strobe low.
// - Data bus driven only while strobe low and read selected.
`timescale 1ns/1ns
module rcr_core
	import rcr_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Sample and sync pins
	input  wire logic [11:0] x_in,
	input  wire logic        ss_n_in,
	input  wire logic        accum_sync_n_in,
	// Control bus
	input  wire logic        cs_n_in,
	input  wire logic        rw_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n_out,
	// Serial outputs
	output logic             i_out,
	output logic             q_out,
	output logic             bit_strobe_out,
	output logic             frame_strobe_out,
	output logic             sync_n_out
);
	// Control bus synchronisation
	logic [13:0] bus_s;
	logic        cs_n_s;
	logic        rw_s;
	logic [3:0]  addr_s;
	logic [7:0]  wdata_s;
	logic        cs_n_prev_r;
	rcr_bus_t    bus_cyc;
	logic        wr_pulse;

	rcr_pin_sync #(.W(14)) u_bus_sync (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.pin_in    ({cs_n_in, rw_in, addr_in, data_in}),
		.level_out (bus_s)
	);
	assign {cs_n_s, rw_s, addr_s, wdata_s} = bus_s;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) cs_n_prev_r <= 1'b1;
		else cs_n_prev_r <= cs_n_s;
	end

	always_comb begin
		bus_cyc = BUS_IDLE;
		if (!cs_n_s && rw_s) bus_cyc = BUS_READ;
		else if (cs_n_prev_r && !cs_n_s && !rw_s) bus_cyc = BUS_WRITE;
	end
	assign wr_pulse = (bus_cyc == BUS_WRITE);

	// Configuration registers 0 to 9
	logic [7:0] cfg_r [NUM_CFG];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_CFG; i++) cfg_r[i] <= CFG_RST;
			cfg_r[REG_RATIO_LO] <= RATIO_LO_RST;
		end else begin
			for (int i = 0; i < NUM_CFG; i++) begin
				if (wr_pulse && addr_s == 4'(i)) cfg_r[i] <= wdata_s;
			end
		end
	end

	logic [7:0]  sc;
	logic [7:0]  of;
	logic [7:0]  ff;
	logic [27:0] tuning_word;
	logic [13:0] downsample_setting;
	logic [3:0]  gain;
	logic [3:0]  rate;
	assign sc          = cfg_r[REG_SYNC];
	assign of          = cfg_r[REG_SERFMT];
	assign ff          = cfg_r[REG_FILTFMT];
	assign tuning_word = {cfg_r[REG_TW_B3][3:0], cfg_r[REG_TW_B2],
		cfg_r[REG_TW_B1], cfg_r[REG_TW_B0]};
	assign downsample_setting = {cfg_r[REG_RATIO_HI][5:0], cfg_r[REG_RATIO_LO]};
	assign gain = cfg_r[REG_SCALE][3:0];
	assign rate = of[OF_RATE_LSB +: 4];

	// Status and capture
	logic        ready_r;
	logic        ovf_r;
	logic [4:0]  st_misc_r;
	logic [31:0] cap_r;
	logic        push;
	logic        ovf_evt;
	logic [31:0] samp;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_r   <= 1'b0;
			st_misc_r <= '0;
			cap_r     <= '0;
		end else begin
			if (push && ready_r) begin
				cap_r   <= samp;
				ready_r <= 1'b0;
			end
			if (wr_pulse && addr_s == REG_STATUS) begin
				ready_r   <= wdata_s[ST_READY];
				st_misc_r <= wdata_s[7:3];
			end
		end
	end

	// Overflow set wins over a software clear in the same cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) ovf_r <= 1'b0;
		else if (push && ovf_evt) ovf_r <= 1'b1;
		else if (wr_pulse && addr_s == REG_STATUS) ovf_r <= wdata_s[ST_OVF];
	end

	function automatic logic [7:0] rd_mux(input logic [3:0] a);
		logic [7:0] st;
		st = {st_misc_r, ovf_r, 1'b0, ready_r} & MASK_STATUS;
		case (a)
			REG_TW_B3, REG_SCALE: rd_mux = cfg_r[a] & MASK_NIBBLE;
			REG_RATIO_HI:         rd_mux = cfg_r[a] & MASK_RATIO;
			REG_STATUS:           rd_mux = st;
			REG_SIGSUM:           rd_mux = 8'h00;
			REG_I_LO:             rd_mux = cap_r[7:0];
			REG_I_HI:             rd_mux = cap_r[15:8];
			REG_Q_LO:             rd_mux = cap_r[23:16];
			REG_Q_HI:             rd_mux = cap_r[31:24];
			default:              rd_mux = cfg_r[a];
		endcase
	endfunction : rd_mux

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_out      <= 8'h00;
			data_oe_n_out <= 1'b1;
		end else begin
			data_out      <= (bus_cyc == BUS_READ) ? rd_mux(addr_s) : 8'h00;
			data_oe_n_out <= (bus_cyc != BUS_READ);
		end
	end

	// Sample-side pins and clock gating
	logic [11:0] x_q_r;
	logic        ss_q_r;
	logic        as_q_r;
	logic        ce;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			x_q_r  <= '0;
			ss_q_r <= 1'b1;
			as_q_r <= 1'b1;
		end else begin
			x_q_r  <= x_in;
			ss_q_r <= ss_n_in;
			as_q_r <= accum_sync_n_in;
		end
	end
	// Gating is a clock enable here; registers simply hold their state
	assign ce = !ff[FF_GATE] || !as_q_r;

	// Sync selection
	logic        ss_eff_n;
	logic        as_sel_n;
	logic [19:0] sync_cnt_r;
	logic        cnt_tc;
	logic        int_sync_n;
	logic        reinit;
	assign ss_eff_n   = sc[SC_SS_OFF] | ss_q_r;
	assign as_sel_n   = (sc[SC_SUBST] && !sc[SC_SS_OFF]) ? ss_q_r : as_q_r;
	assign cnt_tc     = sc[SC_TEST] ? (&sync_cnt_r[SYNC_SHORT_LOG2-1:0]) : (&sync_cnt_r);
	assign int_sync_n = sc[SC_CNT_SEL] ? !cnt_tc : ss_eff_n;
	// Without diagnostic syncs the system sync still aligns the output frame
	assign reinit = sc[SC_RAMP_INPUT_SEL] ? !int_sync_n : !ss_eff_n;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_cnt_r <= '0;
			sync_n_out <= 1'b1;
		end else if (ce) begin
			sync_cnt_r <= cnt_tc ? 20'h00000 : sync_cnt_r + 20'h00001;
			sync_n_out <= int_sync_n;
		end
	end

	// Tuning word load and accumulator
	logic        tw_wr_r;
	logic [27:0] tuning_word_r;
	logic [27:0] acc_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) tw_wr_r <= 1'b0;
		else tw_wr_r <= wr_pulse && (addr_s <= REG_SYNC);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tuning_word_r <= '0;
		end else if (sc[SC_LOAD] && tw_wr_r) begin
			tuning_word_r <= tuning_word;
		end else if (ce && sc[SC_SYNC_LOAD] && !as_sel_n) begin
			tuning_word_r <= tuning_word;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) acc_r <= '0;
		else if (ce && (reinit && sc[SC_RAMP_INPUT_SEL] || sc[SC_RELOAD] && !as_sel_n)) acc_r <= tuning_word_r;
		else if (ce) acc_r <= acc_r + tuning_word_r;
	end

	// Input source and crude mixer / filter
	logic [11:0]        ramp_r;
	logic signed [11:0] src;
	logic signed [12:0] mix_i;
	logic signed [12:0] mix_q;
	logic signed [12:0] prev_i_r;
	logic signed [12:0] prev_q_r;
	logic signed [12:0] flt_i;
	logic signed [12:0] flt_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) ramp_r <= RAMP_START;
		else if (ce && reinit && sc[SC_RAMP_INPUT_SEL]) ramp_r <= RAMP_START;
		else if (ce) ramp_r <= ramp_r + 12'h001;
	end
	assign src   = ff[FF_RAMP] ? $signed(ramp_r) : $signed(x_q_r);
	assign mix_i = 13'(src);
	assign mix_q = acc_r[27] ? 13'(src) : -13'(src);
	// Narrow filter averages two samples; wide one passes straight through
	assign flt_i = ff[FF_WIDE] ? mix_i : 13'((14'(mix_i) + 14'(prev_i_r)) >>> 1);
	assign flt_q = ff[FF_WIDE] ? mix_q : 13'((14'(mix_q) + 14'(prev_q_r)) >>> 1);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_i_r <= '0;
			prev_q_r <= '0;
		end else if (ce) begin
			prev_i_r <= mix_i;
			prev_q_r <= mix_q;
		end
	end

	// Gain with saturation: {overflow, sample}
	function automatic logic [16:0] scale_sat(input logic signed [12:0] v, input logic [3:0] g);
		logic signed [28:0] w;
		w = 29'(v) <<< g;
		if (w > 29'sd32767) scale_sat = {1'b1, 16'h7fff};
		else if (w < -29'sd32768) scale_sat = {1'b1, 16'h8000};
		else scale_sat = {1'b0, w[15:0]};
	endfunction : scale_sat

	// Decimation, stalled by a full FIFO
	logic [13:0] dec_cnt_r;
	logic        par_r;
	logic        fifo_ready;
	logic [16:0] sc_i;
	logic [16:0] sc_q;
	logic        neg_i;
	logic        neg_q;
	logic [15:0] out_i;
	logic [15:0] out_q;
	assign sc_i    = scale_sat(flt_i, gain);
	assign sc_q    = scale_sat(flt_q, gain);
	assign ovf_evt = sc_i[16] | sc_q[16];
	assign neg_i   = ff[FF_OFFSET] & par_r ^ (ff[FF_REAL] & ff[FF_FLIP] & par_r);
	assign neg_q   = ff[FF_OFFSET] & par_r ^ ff[FF_FLIP];
	assign out_i   = neg_i ? -sc_i[15:0] : sc_i[15:0];
	assign out_q   = ff[FF_REAL] ? out_i : (neg_q ? -sc_q[15:0] : sc_q[15:0]);
	assign samp    = {out_q, out_i};
	assign push    = ce && (dec_cnt_r == '0) && fifo_ready;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dec_cnt_r <= '0;
			par_r     <= 1'b0;
		end else if (ce && reinit) begin
			dec_cnt_r <= downsample_setting;
			par_r     <= 1'b0;
		end else if (push) begin
			dec_cnt_r <= downsample_setting;
			par_r     <= !par_r;
		end else if (ce && dec_cnt_r != '0) begin
			dec_cnt_r <= dec_cnt_r - 14'h0001;
		end
	end

	// FIFO to the serialiser
	logic        fifo_valid;
	logic [31:0] fifo_data;
	logic        frame_end;
	rcr_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (ce && dec_cnt_r == '0),
		.in_ready_out  (fifo_ready),
		.in_data_in    (samp),
		.out_valid_out (fifo_valid),
		.out_ready_in  (ce && frame_end),
		.out_data_out  (fifo_data)
	);

	// Serialiser timing
	logic [15:0] bit_div_r;
	logic [16:0] frame_cnt_r;
	logic [16:0] frame_len;
	logic [15:0] bit_last;
	logic        bit_tick;
	logic [3:0]  bit_idx_r;
	logic        half_q_r;
	logic        first_bit_r;
	logic [31:0] word_r;
	assign bit_last  = 16'((17'h00001 << rate) - 17'h00001);
	assign bit_tick  = (bit_div_r == bit_last);
	// Real mode with the frame bit halves the frame period
	assign frame_len = (ff[FF_REAL] && st_misc_r[ST_REALFS-3]) ?
		17'({downsample_setting, 1'b0} + 15'h0002) :
		17'({downsample_setting, 2'b00} + 16'h0004);
	assign frame_end = (frame_cnt_r == frame_len - 17'h00001);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_cnt_r <= '0;
		end else if (ce) begin
			frame_cnt_r <= (reinit || frame_end) ? 17'h00000 : frame_cnt_r + 17'h00001;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_div_r   <= '0;
			bit_idx_r   <= '0;
			half_q_r    <= 1'b0;
			first_bit_r <= 1'b0;
			word_r      <= '0;
		end else if (ce && (frame_end || reinit)) begin
			bit_div_r   <= '0;
			bit_idx_r   <= '0;
			half_q_r    <= 1'b0;
			first_bit_r <= 1'b1;
			if (fifo_valid && frame_end) word_r <= fifo_data;
		end else if (ce) begin
			bit_div_r <= bit_tick ? 16'h0000 : bit_div_r + 16'h0001;
			if (bit_tick) begin
				bit_idx_r   <= bit_idx_r + 4'h1;
				first_bit_r <= 1'b0;
				if (bit_idx_r == 4'hf) half_q_r <= !half_q_r;
			end
		end
	end

	// Serial pins and strobes
	logic [3:0] sel_idx;
	logic       bit_i;
	logic       bit_q;
	logic       bs_raw;
	logic       fs_raw;
	assign sel_idx = ff[FF_MSB] ? 4'hf - bit_idx_r : bit_idx_r;
	assign bit_i   = ff[FF_ILV] ? word_r[{half_q_r, sel_idx}] : word_r[{1'b0, sel_idx}];
	assign bit_q   = ff[FF_ILV] ? bit_i : word_r[{1'b1, sel_idx}];
	assign bs_raw  = of[OF_BS_SHAPE] ? (bit_div_r >= 16'(bit_last + 16'h0001) >> 1) : bit_tick;
	assign fs_raw  = of[OF_FS_SHAPE] ? first_bit_r : frame_end;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			i_out            <= 1'b0;
			q_out            <= 1'b0;
			bit_strobe_out   <= 1'b0;
			frame_strobe_out <= 1'b0;
		end else if (ce) begin
			i_out            <= bit_i;
			q_out            <= bit_q;
			bit_strobe_out   <= bs_raw ^ of[OF_BS_INV];
			frame_strobe_out <= fs_raw ^ of[OF_FS_INV];
		end
	end

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_write_fall;
		cs_n_prev_r && !cs_n_s && !rw_s;
	endsequence
	a_write_stores: assert property (s_write_fall ##0 (addr_s == REG_SCALE) |=>
		cfg_r[REG_SCALE] == $past(wdata_s)) else $error("write not stored");
	a_bus_release: assert property (!(!cs_n_s && rw_s) |=> data_oe_n_out)
		else $error("bus driven outside read");
	a_bus_drive: assert property (!cs_n_s && rw_s |=> !data_oe_n_out)
		else $error("bus not driven in read");
	a_unused_zero: assert property (!cs_n_s && rw_s && addr_s == REG_SCALE |=>
		data_out[7:4] == 4'h0) else $error("unused bits read nonzero");
	a_ss_ignored: assert property (ce && sc[SC_SS_OFF] && !sc[SC_CNT_SEL] |=> sync_n_out)
		else $error("disabled sync seen");
	a_sync_load: assert property (ce && sc[SC_SYNC_LOAD] && !as_sel_n && !(sc[SC_LOAD] && tw_wr_r)
		|=> tuning_word_r == $past(tuning_word)) else $error("sync load missed");
	a_tw_reload: assert property (sc[SC_LOAD] && tw_wr_r |=> tuning_word_r == $past(tuning_word))
		else $error("tuning load missed");
	a_ovf_sticky: assert property (push && ovf_evt |=> ovf_r)
		else $error("overflow flag not set");
	a_sync_wrap: assert property (ce && cnt_tc |=> sync_cnt_r == 20'h00000)
		else $error("sync counter did not wrap");
	a_gate_hold: assert property (!ce |=> $stable(acc_r) && $stable(frame_cnt_r))
		else $error("gated logic moved");
	a_fs_invert: assert property (ce ##1 $stable(of) |-> frame_strobe_out ==
		($past(fs_raw) ^ of[OF_FS_INV])) else $error("frame strobe polarity wrong");
endmodule : rcr_core

// file: logic/rcr_fifo.sv
// Sample FIFO between the decimator and the serialiser.
// Same clock on both sides; ready and valid follow the usual handshake.
`timescale 1ns/1ns
module rcr_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Fill side
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	// Drain side
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic      [W-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = mem_r[rd_ptr_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
			if (pop) rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : rcr_fifo

// file: logic/rcr_pin_sync.sv
// Three-stage synchroniser for a group of asynchronous pins.
// The group changes only once stages two and three agree.
`timescale 1ns/1ns
module rcr_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_out <= '1;
		end else if (s2_r == s3_r) begin
			level_out <= s3_r;
		end
	end
endmodule : rcr_pin_sync
